// ### src/acc_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: 50 MHz system clock, APB register access
// Notes:   Printed offsets are not all multiples of four, so they are indices
package acc_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0]  IDX_PORT_A_PINS      = 8'h05;
  localparam logic [7:0]  IDX_INTERRUPT_CTRL   = 8'h0B;
  localparam logic [7:0]  IDX_PERIPH_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0]  IDX_CONV_RESULT      = 8'h1E;
  localparam logic [7:0]  IDX_CONVERTER_CTRL   = 8'h1F;
  localparam logic [7:0]  IDX_PORT_A_DIR       = 8'h85;
  localparam logic [7:0]  IDX_PERIPH_IRQ_EN    = 8'h8C;
  localparam logic [7:0]  IDX_PIN_ANALOG_CFG   = 8'h9F;
  localparam logic [7:0]  IDX_CCP_CONTROL      = 8'hC0;
  localparam logic [11:0] ADDR_PORT_A_PINS      = {2'h0, IDX_PORT_A_PINS, 2'h0};
  localparam logic [11:0] ADDR_INTERRUPT_CTRL   = {2'h0, IDX_INTERRUPT_CTRL, 2'h0};
  localparam logic [11:0] ADDR_PERIPH_IRQ_FLAGS = {2'h0, IDX_PERIPH_IRQ_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_CONV_RESULT      = {2'h0, IDX_CONV_RESULT, 2'h0};
  localparam logic [11:0] ADDR_CONVERTER_CTRL   = {2'h0, IDX_CONVERTER_CTRL, 2'h0};
  localparam logic [11:0] ADDR_PORT_A_DIR       = {2'h0, IDX_PORT_A_DIR, 2'h0};
  localparam logic [11:0] ADDR_PERIPH_IRQ_EN    = {2'h0, IDX_PERIPH_IRQ_EN, 2'h0};
  localparam logic [11:0] ADDR_PIN_ANALOG_CFG   = {2'h0, IDX_PIN_ANALOG_CFG, 2'h0};
  localparam logic [11:0] ADDR_CCP_CONTROL      = {2'h0, IDX_CCP_CONTROL, 2'h0};

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CC_POWER_BIT = 0;
  localparam int CC_GO_BIT    = 2;
  localparam int CC_CHAN_LSB  = 3;
  localparam int CC_CLK_LSB   = 6;
  localparam int IRQ_DONE_BIT = 6;
  localparam logic [7:0] CONVERTER_CTRL_RST = 8'h00;
  localparam logic [7:0] PORT_A_DIR_RST     = 8'h1F;
  localparam logic [7:0] PORT_A_DIR_MASK    = 8'h1F;
  localparam logic [7:0] IRQ_FLAGS_RST      = 8'h00;
  localparam logic [7:0] IRQ_FLAGS_MASK     = 8'h47;
  localparam logic [7:0] IRQ_EN_RST         = 8'h00;
  localparam logic [7:0] PIN_CFG_RST        = 8'h00;
  localparam logic [7:0] INTERRUPT_CTRL_RST = 8'h00;
  localparam logic [3:0] CCP_MODE_RST       = 4'h0;
  localparam logic [3:0] CCP_MODE_SPECIAL   = 4'hB;

  // ---------------------------------------------------------------
  // Clock select codes and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] CLKSEL_DIV2  = 2'h0;
  localparam logic [1:0] CLKSEL_DIV8  = 2'h1;
  localparam logic [1:0] CLKSEL_DIV32 = 2'h2;
  localparam logic [1:0] CLKSEL_RC    = 2'h3;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RC_TAD_NS     = 4000;
  localparam int RC_TAD_CYCLES = RC_TAD_NS / CLK_PERIOD_NS;
  localparam logic [7:0] HALF_DIV2  = 8'h01;
  localparam logic [7:0] HALF_DIV8  = 8'h04;
  localparam logic [7:0] HALF_DIV32 = 8'h10;
  localparam logic [7:0] HALF_RC    = 8'(RC_TAD_CYCLES / 2);
  localparam logic [4:0] CONV_HALF_TADS = 5'h13;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] clkSel;
    logic [2:0] channel;
    logic       go;
    logic       powerOn;
  } acc_ctrl_s;

  typedef struct packed {
    logic [3:0] chanAnalog;
  } acc_pincfg_s;

endpackage

// ### src/acc_tad_gen.sv
// Purpose: Produces half bit period ticks for the converter
// Assumes: Divided settings count system clocks, RC setting emulated
// Notes:   Counter restarts whenever run is low
`timescale 1ns/10ps
`default_nettype none
module acc_tad_gen
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] clkSel,
  // Tick
  output logic            halfTick
);

  typedef struct packed {
    logic [7:0] cnt;
  } acc_tad_state_s;

  acc_tad_state_s state_reg;
  acc_tad_state_s state_next;
  logic [7:0]     halfLen;

  always_comb begin
    case (clkSel)
      CLKSEL_DIV2:  halfLen = HALF_DIV2;  // [RULE5] [RULE20]
      CLKSEL_DIV8:  halfLen = HALF_DIV8;  // [RULE5] [RULE20]
      CLKSEL_DIV32: halfLen = HALF_DIV32; // [RULE5] [RULE20]
      default:      halfLen = HALF_RC;    // [RULE7]
    endcase
    state_next = state_reg;
    halfTick   = 1'b0;
    if (!run) begin
      state_next.cnt = 8'h00;
    end else if (state_reg.cnt == halfLen - 8'h01) begin
      state_next.cnt = 8'h00;
      halfTick       = 1'b1;
    end else begin
      state_next.cnt = state_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule
`default_nettype wire

// ### src/acc_sar.sv
// Purpose: Successive approximation of one 8-bit sample
// Assumes: Comparator input comes from the analog front end
// Notes:   One result bit per bit period, MSB first
`timescale 1ns/10ps
`default_nettype none
module acc_sar
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Control
  input  wire logic       start,
  input  wire logic       bitTick,
  input  wire logic       cmpHigh,
  // Approximation
  output logic [7:0]      trial,
  output logic [7:0]      value
);

  typedef struct packed {
    logic [7:0] val;
    logic [7:0] mask;
  } acc_sar_state_s;

  acc_sar_state_s state_reg;
  acc_sar_state_s state_next;

  always_comb begin
    state_next = state_reg;
    if (start) begin
      state_next.val  = 8'h00;
      state_next.mask = 8'h80;
    end else if (bitTick && state_reg.mask != 8'h00) begin
      if (cmpHigh) begin
        state_next.val = state_reg.val | state_reg.mask;
      end
      state_next.mask = state_reg.mask >> 1;
    end
  end

  assign trial = state_reg.val | state_reg.mask;
  assign value = state_reg.val;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule
`default_nettype wire

// ### src/acc_adc_ctrl.sv
// Purpose: Converter control with APB register access
// Assumes: Synchronous pin inputs, comparator supplied from outside
// Notes:   Result register keeps its value across srst
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [RULE1] Analog pins must be set as inputs
// [RULE2] Channel and direction never block conversion
// [RULE3] Analog pins read zero in port register
// [RULE4] Digital input pins remain convertible
// [RULE5] Clock select: /2, /8, /32, RC
// [RULE6] Software avoids too short bit periods
// [RULE7] RC bit period typically 4 us
// [RULE8] RC clock above 1 MHz only sleeping
// [RULE9] Pick faster clock for long periods
// [RULE10] Power on before setting go
// [RULE11] Mode 1011 trigger starts powered conversion
// [RULE12] Trigger clears the sixteen bit timer
// [RULE13] Powered off: trigger ignored, timer cleared
// [RULE14] Select channel, acquire before trigger
// [RULE15] Control resets zero, result keeps value
// [RULE16] Completion loads result, clears go, flags
// [RULE17] Conversion lasts nine and half periods
// [RULE18] Channel codes 0..3, top bit reserved
// [RULE19] Wait two periods before next acquisition
// [RULE20] Divided clock counts oscillator cycles
module acc_adc_ctrl
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Port A pins
  input  wire logic [4:0]  portPinIn,
  output logic [4:0]       portPinOut,
  output logic [4:0]       portPinOe,
  // Analog front end
  input  wire logic        cmpHigh,
  output logic [1:0]       muxChannel,
  output logic [7:0]       dacTrial,
  output logic             sampleHold,
  // Capture/compare and timer
  input  wire logic        specialEvent,
  output logic             timerClear,
  // Interrupt line towards the core
  output logic             convIrq
);

  typedef enum logic {ST_IDLE, ST_CONVERT} acc_phase_e;

  typedef struct packed {
    acc_ctrl_s  ctrl;
    logic [7:0] result;
    logic [4:0] portLatch;
    logic [4:0] portDir;
    logic [2:0] pinCfg;
    logic [7:0] irqFlags;
    logic [7:0] irqEn;
    logic [7:0] intCtrl;
    logic [3:0] ccpMode;
    logic [4:0] halfCnt;
    logic       timerClr;
    logic       irqOut;
    logic [31:0] rdata;
    acc_phase_e  phase;
  } acc_state_s;

  acc_state_s  state_reg;
  acc_state_s  state_next;
  acc_pincfg_s pinMap;
  logic        halfTick;
  logic        sarStart;
  logic [7:0]  sarValue;
  logic        wrAcc;
  logic        rdAcc;
  logic        mapped;
  logic        trigStart;
  logic        convDone;
  logic [7:0]  wd;
  logic [7:0]  portRead;

  // ---------------------------------------------------------------
  // Bit clock and approximation register
  // ---------------------------------------------------------------
  acc_tad_gen u_tad (
    .clk      (clk),
    .srst     (srst),
    .run      (state_reg.phase == ST_CONVERT),
    .clkSel   (state_reg.ctrl.clkSel),
    .halfTick (halfTick)
  );

  acc_sar u_sar (
    .clk     (clk),
    .srst    (srst),
    .start   (sarStart),
    .bitTick (halfTick && state_reg.halfCnt[0]),
    .cmpHigh (cmpHigh),
    .trial   (dacTrial),
    .value   (sarValue)
  );

  // ---------------------------------------------------------------
  // Pin configuration decode
  // ---------------------------------------------------------------
  always_comb begin
    case (state_reg.pinCfg)
      3'h4, 3'h5: pinMap.chanAnalog = 4'hB;
      3'h6, 3'h7: pinMap.chanAnalog = 4'h0;
      default:    pinMap.chanAnalog = 4'hF;
    endcase
  end

  // Analog channels read as zero; pin 4 is always digital
  assign portRead = {3'h0, portPinIn[4], portPinIn[3:0] & ~pinMap.chanAnalog}; // [RULE3]

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign wrAcc = psel && penable && pwrite && pstrb[0];
  assign rdAcc = psel && !penable && !pwrite;
  assign wd    = pwdata[7:0];

  always_comb begin
    if (paddr == ADDR_PORT_A_PINS) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_INTERRUPT_CTRL) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_PERIPH_IRQ_FLAGS) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_CONV_RESULT) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_CONVERTER_CTRL) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_PORT_A_DIR) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_PERIPH_IRQ_EN) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_PIN_ANALOG_CFG) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_CCP_CONTROL) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Main state update
  // ---------------------------------------------------------------
  // Trigger start needs power and the special event mode
  assign trigStart = specialEvent && (state_reg.ccpMode == CCP_MODE_SPECIAL)
                     && state_reg.ctrl.powerOn; // [RULE11] [RULE13]
  assign convDone  = (state_reg.phase == ST_CONVERT) && halfTick
                     && (state_reg.halfCnt == CONV_HALF_TADS - 5'h01); // [RULE17]

  always_comb begin
    state_next          = state_reg;
    sarStart            = 1'b0;
    // Timer cleared by every trigger regardless of power
    state_next.timerClr = specialEvent && (state_reg.ccpMode == CCP_MODE_SPECIAL); // [RULE12] [RULE13]

    // Register writes
    if (wrAcc) begin
      if (paddr == ADDR_PORT_A_PINS) begin
        state_next.portLatch = wd[4:0];
      end else if (paddr == ADDR_INTERRUPT_CTRL) begin
        state_next.intCtrl = wd;
      end else if (paddr == ADDR_PERIPH_IRQ_FLAGS) begin
        state_next.irqFlags = wd & IRQ_FLAGS_MASK;
      end else if (paddr == ADDR_CONV_RESULT) begin
        state_next.result = wd;
      end else if (paddr == ADDR_CONVERTER_CTRL) begin
        state_next.ctrl.clkSel  = wd[CC_CLK_LSB +: 2];
        state_next.ctrl.channel = wd[CC_CHAN_LSB +: 3];
        state_next.ctrl.powerOn = wd[CC_POWER_BIT];
        // Go only honoured while already powered; software may also abort
        state_next.ctrl.go      = wd[CC_GO_BIT] && state_reg.ctrl.powerOn; // [RULE10]
      end else if (paddr == ADDR_PORT_A_DIR) begin
        state_next.portDir = wd[4:0];
      end else if (paddr == ADDR_PERIPH_IRQ_EN) begin
        state_next.irqEn = wd & IRQ_FLAGS_MASK;
      end else if (paddr == ADDR_PIN_ANALOG_CFG) begin
        state_next.pinCfg = wd[2:0];
      end else if (paddr == ADDR_CCP_CONTROL) begin
        state_next.ccpMode = wd[3:0];
      end
    end

    if (trigStart) begin
      state_next.ctrl.go = 1'b1; // [RULE11]
    end

    // Conversion sequencing; channel and direction do not gate it
    case (state_reg.phase)
      ST_IDLE: begin
        state_next.halfCnt = 5'h00;
        if (state_reg.ctrl.go && state_reg.ctrl.powerOn) begin // [RULE2] [RULE4]
          state_next.phase = ST_CONVERT;
          sarStart         = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (!state_reg.ctrl.go || !state_reg.ctrl.powerOn) begin
          state_next.phase = ST_IDLE;
        end else if (convDone) begin
          state_next.phase                  = ST_IDLE;
          state_next.result                 = sarValue; // [RULE16]
          state_next.ctrl.go                = 1'b0;     // [RULE16]
          state_next.irqFlags[IRQ_DONE_BIT] = 1'b1;     // [RULE16]
        end else if (halfTick) begin
          state_next.halfCnt = state_reg.halfCnt + 5'h01;
        end
      end
      default: state_next.phase = ST_IDLE;
    endcase

    if (!state_next.ctrl.powerOn) begin
      state_next.ctrl.go = 1'b0;
    end

    state_next.irqOut = |(state_reg.irqFlags & state_reg.irqEn);

    // Read data registered in setup phase
    state_next.rdata = 32'h0000_0000;
    if (rdAcc) begin
      if (paddr == ADDR_PORT_A_PINS) begin
        state_next.rdata[7:0] = portRead;
      end else if (paddr == ADDR_INTERRUPT_CTRL) begin
        state_next.rdata[7:0] = state_reg.intCtrl;
      end else if (paddr == ADDR_PERIPH_IRQ_FLAGS) begin
        state_next.rdata[7:0] = state_reg.irqFlags;
      end else if (paddr == ADDR_CONV_RESULT) begin
        state_next.rdata[7:0] = state_reg.result;
      end else if (paddr == ADDR_CONVERTER_CTRL) begin
        state_next.rdata[7:0] = {state_reg.ctrl.clkSel, state_reg.ctrl.channel,
                                 state_reg.ctrl.go, 1'b0, state_reg.ctrl.powerOn};
      end else if (paddr == ADDR_PORT_A_DIR) begin
        state_next.rdata[7:0] = {3'h0, state_reg.portDir};
      end else if (paddr == ADDR_PERIPH_IRQ_EN) begin
        state_next.rdata[7:0] = state_reg.irqEn;
      end else if (paddr == ADDR_PIN_ANALOG_CFG) begin
        state_next.rdata[7:0] = {5'h00, state_reg.pinCfg};
      end else if (paddr == ADDR_CCP_CONTROL) begin
        state_next.rdata[7:0] = {4'h0, state_reg.ccpMode};
      end
    end else if (psel && penable) begin
      state_next.rdata = state_reg.rdata;
    end
  end

  // ---------------------------------------------------------------
  // Registers; result survives srst
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg.ctrl      <= acc_ctrl_s'({CONVERTER_CTRL_RST[7:2],
                                          CONVERTER_CTRL_RST[0]}); // [RULE15]
      state_reg.portLatch <= 5'h00;
      state_reg.portDir   <= PORT_A_DIR_RST[4:0];
      state_reg.pinCfg    <= PIN_CFG_RST[2:0];
      state_reg.irqFlags  <= IRQ_FLAGS_RST;
      state_reg.irqEn     <= IRQ_EN_RST;
      state_reg.intCtrl   <= INTERRUPT_CTRL_RST;
      state_reg.ccpMode   <= CCP_MODE_RST;
      state_reg.halfCnt   <= 5'h00;
      state_reg.timerClr  <= 1'b0;
      state_reg.irqOut    <= 1'b0;
      state_reg.rdata     <= 32'h0000_0000;
      state_reg.result    <= state_reg.result; // [RULE15]
      state_reg.phase     <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata     = state_reg.rdata;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !mapped;
  assign portPinOut = state_reg.portLatch;
  assign portPinOe  = ~state_reg.portDir;
  assign muxChannel = state_reg.ctrl.channel[1:0]; // [RULE18]
  assign sampleHold = (state_reg.phase == ST_CONVERT);
  assign timerClear = state_reg.timerClr;
  assign convIrq    = state_reg.irqOut;

endmodule
`default_nettype wire

// ### tb/acc_adc_ctrl_assertions.sv
// Purpose: Port checks for the converter control block
// Assumes: Register fields shadowed from APB writes
// Notes:   Conversion length window widens for the RC clock
`timescale 1ns/10ps
`default_nettype none
module acc_adc_ctrl_assertions
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // Converter
  input wire logic        sampleHold,
  input wire logic        specialEvent,
  input wire logic        timerClear,
  input wire logic        convIrq
);
  // --------
  // Shadows
  // --------
  logic        wr, cw, trig, pwr, ien, abt;
  logic [1:0]  sel;
  logic [2:0]  pcfg;
  logic [3:0]  mode, am;
  logic [11:0] cnt, lo, hi;
  assign wr   = psel && penable && pwrite && pstrb[0];
  assign cw   = wr && paddr == ADDR_CONVERTER_CTRL;
  assign trig = specialEvent && mode == CCP_MODE_SPECIAL;
  assign am   = pcfg[2:1] == 2'h3 ? 4'h0 : pcfg[2] ? 4'hB : 4'hF;
  assign lo   = sel == CLKSEL_RC ? 12'h3B6 : 12'(12'h13 << (2 * sel));
  assign hi   = sel == CLKSEL_RC ? 12'hB22 : lo + 12'h3;
  always_ff @(posedge clk) begin
    if (srst) begin
      {pwr, ien, abt, sel, pcfg, mode, cnt} <= '0;
    end else begin
      if (cw) begin
        pwr <= pwdata[CC_POWER_BIT];
        sel <= pwdata[CC_CLK_LSB +: 2];
      end
      if (wr && paddr == ADDR_PIN_ANALOG_CFG) pcfg <= pwdata[2:0];
      if (wr && paddr == ADDR_CCP_CONTROL) mode <= pwdata[3:0];
      if (wr && paddr == ADDR_PERIPH_IRQ_EN) ien <= pwdata[IRQ_DONE_BIT];
      abt <= sampleHold && (abt || (cw && !(pwdata[CC_GO_BIT] && pwdata[CC_POWER_BIT])));
      cnt <= sampleHold ? cnt + 12'h1 : 12'h0;
    end
  end
  // --------
  // Checks
  // --------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_trig_clear: assert property (trig |=> timerClear)
    else $error("timer clear missing after trigger");
  chk_no_clear: assert property (!trig |=> !timerClear)
    else $error("timer clear without trigger");
  chk_trig_start: assert property (trig && pwr && !sampleHold |-> ##[1:3] sampleHold)
    else $error("trigger did not start conversion");
  chk_trig_ignored: assert property (trig && !pwr && !sampleHold |=> !sampleHold [*2])
    else $error("trigger started unpowered converter");
  chk_go_start: assert property (cw && pwr && pwdata[CC_GO_BIT]
    && pwdata[CC_POWER_BIT] && !sampleHold |-> ##[1:3] sampleHold)
    else $error("go write did not start conversion");
  chk_conv_len: assert property ($fell(sampleHold) && !abt |-> cnt >= lo && cnt <= hi)
    else $error("conversion length wrong for clock select");
  chk_done_irq: assert property ($fell(sampleHold) && !abt && ien |-> ##[0:3] convIrq)
    else $error("done interrupt missing");
  chk_port_mask: assert property (psel && penable && !pwrite
    && paddr == ADDR_PORT_A_PINS |-> (prdata[3:0] & am) == 4'h0)
    else $error("analog pin read as nonzero");
endmodule
bind acc_adc_ctrl acc_adc_ctrl_assertions acc_adc_ctrl_assertions_i (.clk, .srst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .sampleHold, .specialEvent,
  .timerClear, .convIrq);
`default_nettype wire

// ### tb/acc_analog_model.sv
// Purpose: Analog pins and comparator seen by the converter
// Assumes: Ideal comparator, pin levels set by the bench
// Notes:   Driven pins convert their own output level
`timescale 1ns/10ps
`default_nettype none
module acc_analog_model
  import acc_pkg::*;
(
  // Bench levels
  input  wire logic [7:0] level [4],
  input  wire logic [4:0] digIn,
  // Converter side
  input  wire logic [1:0] muxChannel,
  input  wire logic [7:0] dacTrial,
  input  wire logic [4:0] portPinOut,
  input  wire logic [4:0] portPinOe,
  output logic            cmpHigh,
  output logic [4:0]      portPinIn
);
  logic [7:0] vin;
  assign vin = portPinOe[muxChannel] ? {8{portPinOut[muxChannel]}} : level[muxChannel];
  assign cmpHigh = vin >= dacTrial;
  assign portPinIn = (portPinOe & portPinOut) | (~portPinOe & digIn);
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero wait APB slave, ideal analog model
// Notes:   Reads note expected data in a queue for the monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin nChecks++; if ((a) !== (e)) begin errCount++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb
  import acc_pkg::*;
;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, cmpHigh;
  logic        sampleHold, specialEvent, timerClear, convIrq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, m;
  logic [4:0]  portPinIn, portPinOut, portPinOe, digIn;
  logic [1:0]  muxChannel, ch;
  logic [7:0]  dacTrial, dir, lat, lastRes, q, c;
  logic [7:0]  level [4];
  logic [7:0]  expQ [$];
  int          errCount, nChecks;

  always #10 clk = ~clk;

  acc_adc_ctrl acc_adc_ctrl_i (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .portPinIn, .portPinOut, .portPinOe, .cmpHigh,
    .muxChannel, .dacTrial, .sampleHold(sampleHold), .specialEvent, .timerClear, .convIrq);
  acc_analog_model acc_analog_model_i (.level, .digIn, .muxChannel, .dacTrial,
    .portPinOut, .portPinOe, .cmpHigh, .portPinIn);

  // --------
  // Tasks
  // --------
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    if (!w) expQ.push_back(d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitConv;
    int n;
    n = 0;
    while (sampleHold !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    while (sampleHold !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (400) @(posedge clk);
  endtask

  task automatic pulse;
    @(posedge clk);
    specialEvent <= 1'b1;
    @(posedge clk);
    specialEvent <= 1'b0;
  endtask

  function automatic logic [7:0] conv(input logic [1:0] k);
    return dir[k] ? level[k] : {8{lat[k]}};
  endfunction

  task automatic testDone;
    $display("Checks %0d, errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // --------
  // Monitor
  // --------
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready && expQ.size() > 0) begin
      q = expQ.pop_front();
      `CHK($sformatf("reg %h", paddr), q, prdata[7:0])
    end
    if (psel && penable && pready) begin
      `CHK("pslverr", paddr == 12'h004, pslverr)
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    errCount++;
    testDone();
  end

  // --------
  // Tests
  // --------
  initial begin
    {clk, psel, penable, pwrite, specialEvent} = '0;
    srst = 1'b1;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    errCount = 0;
    nChecks = 0;
    void'($urandom(32'h28B8));
    digIn = 5'($urandom);
    foreach (level[i]) level[i] = 8'($urandom);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    apb(0, ADDR_CONVERTER_CTRL, 8'h00);
    apb(0, ADDR_PORT_A_DIR, 8'h1F);
    apb(0, ADDR_PERIPH_IRQ_FLAGS, 8'h00);
    apb(0, 12'h004, 8'h00);
    apb(1, ADDR_CONVERTER_CTRL, 8'h04);
    apb(0, ADDR_CONVERTER_CTRL, 8'h00);
    for (int p = 0; p < 8; p++) begin
      m = p[2:1] == 2'h3 ? 4'h0 : p[2] ? 4'hB : 4'hF;
      apb(1, ADDR_PIN_ANALOG_CFG, 8'(p));
      apb(0, ADDR_PORT_A_PINS, {3'h0, digIn & ~{1'b0, m}});
    end
    apb(1, ADDR_PERIPH_IRQ_EN, 8'h40);
    for (int s = 0; s < 8; s++) begin
      ch = 2'($urandom);
      dir = 8'($urandom) & 8'h1F;
      lat = 8'($urandom);
      apb(1, ADDR_PIN_ANALOG_CFG, 8'($urandom_range(7)));
      apb(1, ADDR_PORT_A_DIR, dir);
      apb(1, ADDR_PORT_A_PINS, lat);
      // Ideal comparator: no bit period floor or RC advice to honour
      c = {2'(s), 1'b0, ch, 3'h1};
      apb(1, ADDR_CONVERTER_CTRL, c);
      apb(1, ADDR_CONVERTER_CTRL, c | 8'h04);
      waitConv();
      lastRes = conv(ch);
      apb(0, ADDR_CONVERTER_CTRL, c);
      apb(0, ADDR_CONV_RESULT, lastRes);
      apb(0, ADDR_PERIPH_IRQ_FLAGS, 8'h40);
      apb(1, ADDR_PERIPH_IRQ_FLAGS, 8'h00);
    end
    // Abort in mid conversion
    apb(1, ADDR_CONVERTER_CTRL, 8'hC5);
    repeat (50) @(posedge clk);
    apb(1, ADDR_CONVERTER_CTRL, 8'hC1);
    apb(0, ADDR_CONV_RESULT, lastRes);
    apb(0, ADDR_PERIPH_IRQ_FLAGS, 8'h00);
    repeat (400) @(posedge clk);
    // Capture/compare trigger
    apb(1, ADDR_CCP_CONTROL, 8'h0B);
    apb(1, ADDR_CONVERTER_CTRL, 8'h01);
    pulse();
    waitConv();
    lastRes = conv(2'h0);
    apb(0, ADDR_CONV_RESULT, lastRes);
    apb(1, ADDR_CONVERTER_CTRL, 8'h00);
    pulse();
    repeat (10) @(posedge clk);
    apb(0, ADDR_CONVERTER_CTRL, 8'h00);
    apb(1, ADDR_CCP_CONTROL, 8'h00);
    pulse();
    // Reset during a conversion
    apb(1, ADDR_CONVERTER_CTRL, 8'h01);
    apb(1, ADDR_CONVERTER_CTRL, 8'h45);
    repeat (10) @(posedge clk);
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    apb(0, ADDR_CONVERTER_CTRL, 8'h00);
    apb(0, ADDR_CONV_RESULT, lastRes);
    apb(0, ADDR_PORT_A_DIR, 8'h1F);
    repeat (4) @(posedge clk);
    testDone();
  end
endmodule
`default_nettype wire
